// ---- tsq_regs.svh ----
// register offsets, field positions, reset values and response codes for the
// touch converter sequencer; assumes 32-bit word-aligned AXI4-Lite access
// What this block does
// - two read-only mirrors of active entry words
// - wait settle_cycles converter ticks before converting
// - pos_input_select field picks converter positive input
// - neg_input_select: 0 reference mux, 1 ground
// - pos_ref_select picks positive reference source
// - low word bits 13:2 drive bias switches
// - neg_ref_select picks negative reference source
// - sixteen-entry result queue, value plus entry tag
// - full queue holds off further queue writes
// - reading results pops the oldest entry
// - result word: value 15:6, tag 3:0
// - interrupt output is status AND enable
// - enables: global bit 6, sources bits 4:0
// - clock_divider_select divides by two to the power
// - modes 00/11 power off, force brownout status
// - mode 01 standby: wake, convert, return, clear brownout
// - mode 10 always running, clears brownout
// - bit 5 switches reference buffer on
// - sequence runs sequence_length plus one conversions
// - power mode gates clock, bandgap, converter; idle gates clock and standby converter
// - full queue keeps measuring and flags overrun
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH

`define TSQ_OFS_HIGH      8'h00
`define TSQ_OFS_LOW       8'h04
`define TSQ_OFS_RESULT    8'h08
`define TSQ_OFS_IRQ_EN    8'h0c
`define TSQ_OFS_POWER     8'h10

`define TSQ_IRQ_EN_MASK   32'h0000_005f
`define TSQ_POWER_MASK    32'h0000_07ef
`define TSQ_IRQ_EN_RESET  32'h0000_0000
`define TSQ_POWER_RESET   32'h0000_0000

`define TSQ_IE_GLOBAL     6
`define TSQ_PC_DIV_HI     10
`define TSQ_PC_DIV_LO     8
`define TSQ_PC_MODE_HI    7
`define TSQ_PC_MODE_LO    6
`define TSQ_PC_REF_BUF    5
`define TSQ_PC_LEN_HI     3

`define TSQ_RESP_OKAY     2'b00
`define TSQ_RESP_SLVERR   2'b10

`endif

// ---- tsq_pkg.sv ----
// types shared by the touch converter sequencer
// assumes tsq_regs.svh carries the numeric constants
package tsq_pkg;

    // control-bank high word, bits 15:0
    typedef struct packed {
        logic [8:0] settle_cycles;
        logic [3:0] pos_input_select;
        logic       neg_input_select;
        logic [1:0] pos_ref_select;
    } tsq_high_t;

    // control-bank low word, bits 13:0
    typedef struct packed {
        logic [11:0] bias_switch_field;
        logic [1:0]  neg_ref_select;
    } tsq_low_t;

    // one queued result
    typedef struct packed {
        logic [9:0] conversion_value;
        logic [3:0] entry_tag;
    } tsq_result_t;

    typedef enum logic [1:0] {
        TSQ_MODE_OFF0    = 2'b00,
        TSQ_MODE_STANDBY = 2'b01,
        TSQ_MODE_RUN     = 2'b10,
        TSQ_MODE_OFF3    = 2'b11
    } tsq_mode_t;

    typedef enum {
        TSQ_IDLE,
        TSQ_LOAD,
        TSQ_SETTLE,
        TSQ_CONVERT,
        TSQ_STORE
    } tsq_state_t;

endpackage

// ---- tsq_sequencer.sv ----
// touch converter sequencer with AXI4-Lite register slave
// assumes the control bank answers bank_index in the same cycle and the
// converter pulses conv_done with conv_result after a conv_start pulse
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tsq_regs.svh"

module tsq_sequencer
    import tsq_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        start_sequence_bit,
    input  wire logic        pen_detect,
    input  wire logic        brownout_cmp,
    input  wire logic [3:0]  watermark_level,
    output logic [3:0]       bank_index,
    input  wire tsq_high_t   bank_high,
    input  wire tsq_low_t    bank_low,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_result,
    output tsq_high_t        active_high,
    output tsq_low_t         active_low,
    output logic             converter_clock,
    output logic             bandgap_on,
    output logic             converter_on,
    output logic             ref_buffer_enable,
    output logic             brownout_status,
    output logic [4:0]       irq_lines
);

    initial
    begin
        if (FIFO_DEPTH != 16)
            $error("result queue depth must be 16");
    end

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic [31:0]        interrupt_enables;
    logic [31:0]        power_configuration;
    tsq_state_t         state;
    logic [8:0]         settle_left;
    logic [6:0]         div_cnt;
    logic               tick;
    tsq_result_t        fifo_mem [FIFO_DEPTH];
    logic [3:0]         wr_ptr;
    logic [3:0]         rd_ptr;
    logic [4:0]         fifo_count;
    logic               eos_status;
    logic               overrun_status;
    logic               aw_held;
    logic               w_held;
    logic [7:0]         aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;

    wire tsq_mode_t mode = tsq_mode_t'(power_configuration[`TSQ_PC_MODE_HI:`TSQ_PC_MODE_LO]);
    wire logic [2:0] div_sel = power_configuration[`TSQ_PC_DIV_HI:`TSQ_PC_DIV_LO];
    wire logic [3:0] seq_len = power_configuration[`TSQ_PC_LEN_HI:0];
    wire logic powered = (mode == TSQ_MODE_STANDBY) || (mode == TSQ_MODE_RUN);
    wire logic busy = (state != TSQ_IDLE);
    wire logic fifo_full = (fifo_count == 5'(FIFO_DEPTH));
    wire logic do_store = (state == TSQ_STORE);
    wire logic push = do_store && !fifo_full;
    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    wire logic pop = ar_take && (s_axi_araddr == `TSQ_OFS_RESULT) && (fifo_count != 5'h0);
    wire logic start_req = powered && (start_sequence_bit || pen_detect);
    wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire logic [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                                   {8{w_strb[1]}}, {8{w_strb[0]}}};

    // ----------------------------------------------------------------
    // converter clock divider
    // ----------------------------------------------------------------
    // tick every 2^div_sel cycles of aclk
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt <= 7'h00;
            tick    <= 1'b0;
        end
        else if (clk_en)
        begin
            div_cnt <= div_cnt + 7'h01;
            tick    <= ((div_cnt & 7'((8'h01 << div_sel) - 8'h01))
                        == 7'((8'h01 << div_sel) - 8'h01));
        end
    end

    // ----------------------------------------------------------------
    // control bank sequencer
    // ----------------------------------------------------------------
    // fetch, settle, convert, store, advance through the entries
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state       <= TSQ_IDLE;
            bank_index  <= 4'h0;
            settle_left <= 9'h000;
            conv_start  <= 1'b0;
            active_high <= '0;
            active_low  <= '0;
        end
        else if (clk_en)
        begin
            conv_start <= 1'b0;
            case (state)
                TSQ_IDLE:
                begin
                    if (start_req)
                    begin
                        bank_index <= 4'h0;
                        state      <= TSQ_LOAD;
                    end
                end
                TSQ_LOAD:
                begin
                    active_high <= bank_high;
                    active_low  <= bank_low;
                    settle_left <= bank_high.settle_cycles;
                    state       <= TSQ_SETTLE;
                end
                TSQ_SETTLE:
                begin
                    if (!powered)
                        state <= TSQ_IDLE;
                    else if (settle_left == 9'h000)
                    begin
                        conv_start <= 1'b1;
                        state      <= TSQ_CONVERT;
                    end
                    else if (tick)
                        settle_left <= settle_left - 9'h001;
                end
                TSQ_CONVERT:
                begin
                    if (!powered)
                        state <= TSQ_IDLE;
                    else if (conv_done)
                        state <= TSQ_STORE;
                end
                TSQ_STORE:
                begin
                    if (bank_index == seq_len)
                        state <= TSQ_IDLE;
                    else
                    begin
                        bank_index <= bank_index + 4'h1;
                        state      <= TSQ_LOAD;
                    end
                end
                default:
                    state <= TSQ_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // result queue
    // ----------------------------------------------------------------
    // store the value and tag; drop the result when full
    logic [9:0] last_result;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            last_result <= 10'h000;
        else if (clk_en && state == TSQ_CONVERT && conv_done)
            last_result <= conv_result;
    end

    always_ff @(posedge aclk)
    begin
        if (clk_en && push)
            fifo_mem[wr_ptr] <= '{conversion_value: last_result, entry_tag: bank_index};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr     <= 4'h0;
            rd_ptr     <= 4'h0;
            fifo_count <= 5'h00;
        end
        else if (clk_en)
        begin
            if (push)
                wr_ptr <= wr_ptr + 4'h1;
            if (pop)
                rd_ptr <= rd_ptr + 4'h1;
            fifo_count <= fifo_count + 5'(push) - 5'(pop);
        end
    end

    // ----------------------------------------------------------------
    // status and interrupt outputs
    // ----------------------------------------------------------------
    // sequence end and overrun are sticky until the next start
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            eos_status     <= 1'b0;
            overrun_status <= 1'b0;
        end
        else if (clk_en)
        begin
            if (do_store && bank_index == seq_len)
                eos_status <= 1'b1;
            else if (state == TSQ_IDLE && start_req)
                eos_status <= 1'b0;
            if (do_store && fifo_full)
                overrun_status <= 1'b1;
            else if (state == TSQ_IDLE && start_req)
                overrun_status <= 1'b0;
        end
    end

    // brownout status, power gates and masked interrupt lines
    wire logic [4:0] raw_status = {brownout_status, pen_detect, eos_status,
                                   fifo_count > {1'b0, watermark_level}, overrun_status};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            brownout_status   <= 1'b1;
            converter_clock   <= 1'b0;
            bandgap_on        <= 1'b0;
            converter_on      <= 1'b0;
            ref_buffer_enable <= 1'b0;
            irq_lines         <= 5'h00;
        end
        else if (clk_en)
        begin
            brownout_status   <= powered ? brownout_cmp : 1'b1;
            converter_clock   <= powered && busy && tick;
            bandgap_on        <= powered;
            converter_on      <= (mode == TSQ_MODE_RUN) || (powered && busy);
            ref_buffer_enable <= power_configuration[`TSQ_PC_REF_BUF];
            irq_lines         <= raw_status & interrupt_enables[4:0]
                                 & {5{interrupt_enables[`TSQ_IE_GLOBAL]}};
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    // address and data accepted in either order, answered together
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held             <= 1'b0;
            w_held              <= 1'b0;
            aw_addr             <= 8'h00;
            w_data              <= 32'h0000_0000;
            w_strb              <= 4'h0;
            s_axi_bvalid        <= 1'b0;
            s_axi_bresp         <= `TSQ_RESP_OKAY;
            interrupt_enables   <= `TSQ_IRQ_EN_RESET;
            power_configuration <= `TSQ_POWER_RESET;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `TSQ_RESP_OKAY;
                if (aw_addr == `TSQ_OFS_IRQ_EN)
                    interrupt_enables <= ((interrupt_enables & ~strb_mask)
                        | (w_data & strb_mask)) & `TSQ_IRQ_EN_MASK;
                else if (aw_addr == `TSQ_OFS_POWER)
                    power_configuration <= ((power_configuration & ~strb_mask)
                        | (w_data & strb_mask)) & `TSQ_POWER_MASK;
                else if (aw_addr != `TSQ_OFS_HIGH && aw_addr != `TSQ_OFS_LOW
                         && aw_addr != `TSQ_OFS_RESULT)
                    s_axi_bresp <= `TSQ_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    // one read in flight; the result register pops on acceptance
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `TSQ_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `TSQ_RESP_OKAY;
                case (s_axi_araddr)
                    `TSQ_OFS_HIGH:   s_axi_rdata <= {16'h0000, active_high};
                    `TSQ_OFS_LOW:    s_axi_rdata <= {18'h00000, active_low};
                    `TSQ_OFS_RESULT: s_axi_rdata <= (fifo_count == 5'h00) ? 32'h0000_0000
                        : {16'h0000, fifo_mem[rd_ptr].conversion_value, 2'b00,
                           fifo_mem[rd_ptr].entry_tag};
                    `TSQ_OFS_IRQ_EN: s_axi_rdata <= interrupt_enables;
                    `TSQ_OFS_POWER:  s_axi_rdata <= power_configuration;
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `TSQ_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);

    a_queue_never_over: assert property (fifo_count <= 5'd16)
        else $error("result queue count above sixteen");
    a_full_no_push: assert property (fifo_full && do_store && !pop
        |=> fifo_count == 5'd16 && overrun_status)
        else $error("full queue accepted a write or missed overrun");
    a_pop_on_read: assert property (pop && !push |=> fifo_count == $past(fifo_count) - 5'd1)
        else $error("result read did not remove an entry");
    a_irq_gate_and: assert property (##1 irq_lines == ($past(raw_status)
        & $past(interrupt_enables[4:0]) & {5{$past(interrupt_enables[6])}}))
        else $error("interrupt line not status and enable");
    a_off_brownout: assert property (!powered |=> brownout_status && !bandgap_on
        && !converter_on && !converter_clock)
        else $error("off mode did not force brownout and gate power");
    a_run_conv_on: assert property (mode == TSQ_MODE_RUN |=> converter_on && bandgap_on)
        else $error("run mode did not keep converter on");
    a_idle_standby: assert property (mode == TSQ_MODE_STANDBY && !busy
        |=> !converter_on && bandgap_on && !converter_clock)
        else $error("standby idle left converter on");
    a_mirror_load: assert property (state == TSQ_LOAD |=> active_high == $past(bank_high)
        && active_low == $past(bank_low))
        else $error("mirror words not loaded from active entry");
    a_settle_zero: assert property (state == TSQ_SETTLE && settle_left == 9'h000 && powered
        |=> conv_start && state == TSQ_CONVERT)
        else $error("settle end did not start conversion");
    a_seq_end_idle: assert property (do_store && bank_index == seq_len
        |=> state == TSQ_IDLE && eos_status)
        else $error("sequence did not end after length plus one");
    a_ref_buffer: assert property (##1 ref_buffer_enable == $past(power_configuration[5]))
        else $error("reference buffer not following its bit");
    a_reserved_zero: assert property ((interrupt_enables & ~`TSQ_IRQ_EN_MASK) == 32'h0
        && (power_configuration & ~`TSQ_POWER_MASK) == 32'h0)
        else $error("reserved register bits not zero");
    a_write_answer: assert property (wr_fire |=> s_axi_bvalid)
        else $error("write not answered");

endmodule

// ---- tsq_front_end.sv ----
// stand-in control bank and converter for the sequencer bench
// assumes conv_start is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
module tsq_front_end
    import tsq_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       slow,
    input  wire logic [3:0] bank_index,
    output tsq_high_t       bank_high,
    output tsq_low_t        bank_low,
    input  wire logic       conv_start,
    output logic            conv_done,
    output logic [9:0]      conv_result
);
    logic [4:0] wait_cnt;
    logic [3:0] tag;
    // bank entries follow the index at once; bias bits 9:7 kept zero
    always_comb
    begin
        bank_high = {5'h00, bank_index, bank_index, bank_index[0], bank_index[1:0]};
        bank_low  = {bank_index[1:0], 3'b000, ~bank_index, 3'b101, ~bank_index[3:2]};
    end
    // converter answers after a short or long wait; result is junk between answers
    always_ff @(posedge aclk)
    begin
        conv_done   <= 1'b0;
        conv_result <= ~conv_result;
        if (!aresetn)
        begin
            wait_cnt    <= 5'h00;
            conv_result <= 10'h155;
        end
        else if (conv_start)
        begin
            wait_cnt <= slow ? 5'h0c : 5'h03;
            tag      <= bank_index;
        end
        else if (wait_cnt != 5'h00)
            wait_cnt <= wait_cnt - 5'h01;
        if (aresetn && !conv_start && wait_cnt == 5'h01)
        begin
            conv_done   <= 1'b1;
            conv_result <= {tag, 6'h15};
        end
    end
endmodule

// ---- tsq_sequencer_tb_top.sv ----
// self-checking bench for the sequencer and its register slave
// assumes tsq_front_end models the control bank and converter
`timescale 1ns/1ps
`include "tsq_regs.svh"
module tsq_sequencer_tb_top
    import tsq_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, slow = 1'b0;
    logic        start_sequence_bit = 1'b0, pen_detect = 1'b0, brownout_cmp = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0]  s_axi_wstrb = 4'hf, watermark_level = 4'h2, bank_index;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        conv_start, conv_done, converter_clock, bandgap_on, converter_on;
    logic        ref_buffer_enable, brownout_status;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [9:0]  conv_result;
    logic [4:0]  irq_lines;
    tsq_high_t   bank_high, active_high;
    tsq_low_t    bank_low, active_low;
    int          n_fail = 0, tests_run = 0;

    tsq_sequencer #(.FIFO_DEPTH(16)) dut_u (.aclk, .aresetn, .clk_en,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata(rd), .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .start_sequence_bit, .pen_detect, .brownout_cmp,
        .watermark_level, .bank_index, .bank_high, .bank_low, .conv_start, .conv_done,
        .conv_result, .active_high, .active_low, .converter_clock, .bandgap_on,
        .converter_on, .ref_buffer_enable, .brownout_status, .irq_lines);
    tsq_front_end fe_u (.aclk, .aresetn, .slow, .bank_index, .bank_high, .bank_low,
        .conv_start, .conv_done, .conv_result);

    // 200 MHz clock
    initial
    begin
        forever #2.5 aclk = ~aclk;
    end
    // watchdog: the tests need under 2000 cycles
    initial
    begin
        #40000;
        n_fail++;
        end_sim();
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // axi write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    // axi read and compare; response code left in rr
    task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rr = s_axi_rresp;
        chk(what, rd, exp);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // start a sequence by software or pen, then wait for end of sequence
    task automatic trig(input logic pen);
        if (pen)
            pen_detect <= 1'b1;
        else
            start_sequence_bit <= 1'b1;
        @(posedge aclk);
        pen_detect <= 1'b0;
        start_sequence_bit <= 1'b0;
        repeat (3) @(posedge aclk);
        while (irq_lines[2] !== 1'b1)
            @(posedge aclk);
        repeat (2) @(posedge aclk);
    endtask

    // mirrors and analog enable seen at every conversion start
    always @(posedge aclk)
    begin
        if (conv_start === 1'b1)
        begin
            chk("high mirror", 32'(active_high), 32'(bank_high));
            chk("low mirror", 32'(active_low), 32'(bank_low));
            chk("analog on", 32'(converter_on), 32'h1);
        end
    end

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset brownout", 32'(brownout_status), 32'h1);
        rc("reset power", `TSQ_OFS_POWER, 32'h0);
        rc("reset enables", `TSQ_OFS_IRQ_EN, 32'h0);
        $display("test reset done");
        wr(`TSQ_OFS_IRQ_EN, 32'hffff_ffff);
        rc("enables", `TSQ_OFS_IRQ_EN, 32'h0000_005f);
        wr(`TSQ_OFS_POWER, 32'hffff_fba2);
        rc("power", `TSQ_OFS_POWER, 32'h0000_03a2);
        chk("run brownout", 32'(brownout_status), 32'h0);
        chk("ref buffer", 32'(ref_buffer_enable), 32'h1);
        chk("run gates", 32'({bandgap_on, converter_on}), 32'h3);
        rc("unmapped", 8'h40, 32'h0);
        chk("unmapped resp", 32'(rr), 32'(`TSQ_RESP_SLVERR));
        rc("empty queue", `TSQ_OFS_RESULT, 32'h0);
        $display("test registers done");
        trig(1'b0);
        chk("irq lines", 32'(irq_lines), 32'h06);
        wr(`TSQ_OFS_IRQ_EN, 32'h0000_001f);
        chk("global off", 32'(irq_lines), 32'h0);
        wr(`TSQ_OFS_IRQ_EN, 32'h0000_0044);
        chk("eos only", 32'(irq_lines), 32'h04);
        rc("high word", `TSQ_OFS_HIGH, 32'h0000_0112);
        rc("low word", `TSQ_OFS_LOW, 32'h0000_21b7);
        for (int i = 0; i < 3; i++)
            rc("result", `TSQ_OFS_RESULT, {16'h0, 4'(i), 6'h15, 2'b00, 4'(i)});
        rc("drained", `TSQ_OFS_RESULT, 32'h0);
        $display("test sequence done");
        slow <= 1'b1;
        wr(`TSQ_OFS_POWER, 32'h0000_034f);
        wr(`TSQ_OFS_IRQ_EN, 32'h0000_0045);
        trig(1'b1);
        chk("full no overrun", 32'(irq_lines), 32'h04);
        wr(`TSQ_OFS_POWER, 32'h0000_0340);
        trig(1'b0);
        chk("overrun", 32'(irq_lines), 32'h05);
        chk("standby idle", 32'({bandgap_on, converter_on}), 32'h2);
        for (int i = 0; i < 16; i++)
            rc("queued", `TSQ_OFS_RESULT, {16'h0, 4'(i), 6'h15, 2'b00, 4'(i)});
        rc("dropped", `TSQ_OFS_RESULT, 32'h0);
        $display("test overrun done");
        wr(`TSQ_OFS_POWER, 32'h0000_00c0);
        chk("off brownout", 32'(brownout_status), 32'h1);
        chk("off gates", 32'({bandgap_on, converter_on}), 32'h0);
        $display("test power off done");
        end_sim();
    end
endmodule
